// ===== hdl/rbl_pkg.sv
// Purpose: constants and types for the ratio/bias loop conversion block
// Assumes: apb slave, 32-bit data, one aligned word per register
// Notes: offsets below are the block's own register map
package rbl_pkg;
    localparam logic [7:0] REG_MODE = 8'h00;
    localparam logic [7:0] REG_RATIO1 = 8'h04;
    localparam logic [7:0] REG_BIAS1 = 8'h08;
    localparam logic [7:0] REG_RATIO2 = 8'h0C;
    localparam logic [7:0] REG_BIAS2 = 8'h10;
    localparam logic [7:0] REG_CTRL = 8'h14;
    localparam logic [7:0] REG_STOP = 8'h18;
    localparam logic [7:0] REG_RESULT1 = 8'h1C;
    localparam logic [7:0] REG_RESULT2 = 8'h20;
    localparam logic [7:0] REG_STATUS = 8'h24;
    localparam logic [7:0] REG_RANGE = 8'h28;
    localparam logic [7:0] REG_CAL = 8'h2C;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_POS = 2'h1;
    localparam logic [1:0] MODE_NEG = 2'h2;
    localparam logic [1:0] STOP_CLR = 2'h0;
    localparam logic [1:0] STOP_HOLD = 2'h1;
    localparam logic [1:0] STOP_MAX = 2'h2;
    localparam logic signed [17:0] FS_4000 = 18'sd4000;
    localparam logic signed [17:0] FS_8000 = 18'sd8000;
    localparam logic signed [17:0] FS_BIP_4000 = 18'sd2000;
    localparam logic signed [17:0] FS_BIP_8000 = 18'sd4000;
    localparam int RESP_4000_NS = 850000;
    localparam int RESP_8000_NS = 420000;
    localparam int CLK_NS = 20;
    localparam int RESP_4000_CYC = RESP_4000_NS / CLK_NS;
    localparam int RESP_8000_CYC = RESP_8000_NS / CLK_NS;
    localparam int CONV_CYC = 8;
    typedef enum logic [2:0] {
        RBL_IDLE = 3'b000,
        RBL_MUL = 3'b001,
        RBL_ADD = 3'b011,
        RBL_CLAMP = 3'b010,
        RBL_DONE = 3'b110
    } rbl_state_t;
    typedef struct packed {
        logic [1:0] mode;
        logic [15:0] ratio;
        logic signed [15:0] bias;
    } rbl_loop_cfg_t;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } rbl_apb_req_t;
endpackage : rbl_pkg

// ===== hdl/rbl_loop_conv.sv
// Purpose: two ratio/bias loops turning input counts into output counts
// Assumes: inputs arrive synchronous to pclk; sample_valid pulses per input update
// Notes: loop mode, ratio and bias are latched only on a restart pulse or reset; ctrl, stop and range act at once; cal is only stored and read back
`timescale 1ns/100ps
module rbl_loop_conv
    import rbl_pkg::*;
(
    input wire logic pclk, // clock 50 MHz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic unit_restart, // one-cycle restart pulse
    input wire logic [1:0] sample_valid, // per input new sample pulse
    input wire logic signed [15:0] in1_count, // input 1 conversion count
    input wire logic signed [15:0] in2_count, // input 2 conversion count
    input wire logic [1:0] in_disconnect, // per input wire break
    input wire logic run_mode, // controller in run mode
    input wire logic adjust_mode, // unit in adjustment mode
    output logic signed [15:0] out1_count, // output 1 drive count
    output logic signed [15:0] out2_count, // output 2 drive count
    output logic signed [15:0] input_word1, // reported input 1 word
    output logic signed [15:0] input_word2, // reported input 2 word
    output logic [1:0] scaling_allowed, // per loop output scaling permitted
    output logic [1:0] conv_done // per loop result pulse
);
    rbl_loop_cfg_t cfg_q [2]; // active copy
    rbl_loop_cfg_t shd_q [2]; // software shadow
    logic [7:0] mode_sh_q;
    logic [1:0] out_en_q;
    logic [3:0] stop_q;
    logic [1:0] range_q; // bit0 bipolar, bit1 8000 resolution
    logic signed [15:0] cal_ofs_q, cal_gain_q;
    logic signed [15:0] out_q [2];
    logic signed [15:0] word_q [2];
    logic [1:0] done_q;
    logic [1:0] clamp_q;
    logic hold_all_q;
    rbl_state_t st_q [2];
    logic signed [15:0] smp_q [2];
    logic signed [37:0] acc_q [2];
    wire bus_wr = psel && penable && pwrite;
    wire bus_rd = psel && penable && !pwrite;

    function automatic logic [13:0] bcd_to_bin(input logic [15:0] b);
        bcd_to_bin = 14'(b[15:12] * 1000 + b[11:8] * 100 + b[7:4] * 10 + b[3:0]);
    endfunction : bcd_to_bin

    function automatic logic signed [17:0] full_scale(input logic [1:0] r);
        case (r)
            2'b00: full_scale = FS_4000;
            2'b01: full_scale = FS_BIP_4000;
            2'b10: full_scale = FS_8000;
            default: full_scale = FS_BIP_8000;
        endcase
    endfunction : full_scale

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a <= REG_CAL) && (a[1:0] == 2'b00);
    endfunction : mapped

    logic signed [17:0] fs;
    logic signed [17:0] lo_lim, hi_lim;
    always_comb begin
        fs = full_scale(range_q);
        // output span runs -5 % to +105 % of full scale; bipolar is symmetric
        hi_lim = fs + (fs / 18'sd20);
        lo_lim = range_q[0] ? -hi_lim : -(fs / 18'sd20);
    end

    // apb: zero wait state, write takes effect in access phase
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_sh_q <= 8'h00;
            shd_q[0] <= '0;
            shd_q[1] <= '0;
            out_en_q <= 2'b00;
            stop_q <= 4'h0;
            range_q <= 2'b00;
            cal_ofs_q <= 16'sh0000;
            cal_gain_q <= 16'sh0000;
        end else if (bus_wr) begin
            case (paddr)
                REG_MODE: mode_sh_q <= pwdata[7:0];
                REG_RATIO1: shd_q[0].ratio <= pwdata[15:0];
                REG_BIAS1: shd_q[0].bias <= pwdata[15:0];
                REG_RATIO2: shd_q[1].ratio <= pwdata[15:0];
                REG_BIAS2: shd_q[1].bias <= pwdata[15:0];
                REG_CTRL: out_en_q <= pwdata[1:0];
                REG_STOP: stop_q <= pwdata[3:0];
                REG_RANGE: range_q <= pwdata[1:0];
                REG_CAL: begin
                    cal_ofs_q <= pwdata[15:0];
                    cal_gain_q <= pwdata[31:16];
                end
                default: ;
            endcase
        end
    end

    // mode and constants only become active at restart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q[0] <= '0;
            cfg_q[1] <= '0;
        end else if (unit_restart) begin
            cfg_q[0] <= '{mode: mode_sh_q[1:0], ratio: shd_q[0].ratio, bias: shd_q[0].bias};
            cfg_q[1] <= '{mode: mode_sh_q[3:2], ratio: shd_q[1].ratio, bias: shd_q[1].bias};
        end
    end

    // adjustment in run mode freezes both loops, their words and outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_all_q <= 1'b0;
        end else begin
            hold_all_q <= adjust_mode && run_mode;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : loop_g
            wire active = (cfg_q[g].mode == MODE_POS) || (cfg_q[g].mode == MODE_NEG);
            wire signed [15:0] raw = (g == 0) ? in1_count : in2_count;
            logic signed [37:0] sum;
            logic signed [15:0] clamped;
            logic clip;
            always_comb begin
                // acc holds ratio*input in hundredths
                sum = (cfg_q[g].mode == MODE_NEG) ?
                    38'(fs) * 38'sd100 - acc_q[g] + 38'(cfg_q[g].bias) * 38'sd100 :
                    acc_q[g] + 38'(cfg_q[g].bias) * 38'sd100;
                sum = sum / 38'sd100;
                clip = 1'b1;
                if (sum > 38'(hi_lim)) begin
                    clamped = 16'(hi_lim);
                end else if (sum < 38'(lo_lim)) begin
                    clamped = 16'(lo_lim);
                end else begin
                    clamped = 16'(sum);
                    clip = 1'b0;
                end
            end
            // short fixed pipeline, well inside both response budgets
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    st_q[g] <= RBL_IDLE;
                    smp_q[g] <= 16'sh0000;
                    acc_q[g] <= '0;
                end else if (!hold_all_q) begin
                    case (st_q[g])
                        RBL_IDLE: if (sample_valid[g] && active) begin
                            smp_q[g] <= raw;
                            st_q[g] <= RBL_MUL;
                        end
                        RBL_MUL: begin
                            acc_q[g] <= 38'(smp_q[g]) * 38'(bcd_to_bin(cfg_q[g].ratio));
                            st_q[g] <= RBL_ADD;
                        end
                        RBL_ADD: st_q[g] <= RBL_CLAMP;
                        RBL_CLAMP: st_q[g] <= RBL_DONE;
                        RBL_DONE: st_q[g] <= RBL_IDLE;
                        default: st_q[g] <= RBL_IDLE;
                    endcase
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    out_q[g] <= 16'sh0000;
                    word_q[g] <= 16'sh0000;
                    done_q[g] <= 1'b0;
                    clamp_q[g] <= 1'b0;
                end else if (hold_all_q) begin
                    done_q[g] <= 1'b0;
                end else begin
                    done_q[g] <= (st_q[g] == RBL_DONE);
                    if (!active) begin
                        if (sample_valid[g]) begin
                            word_q[g] <= raw;
                        end
                    end else if (in_disconnect[g]) begin
                        word_q[g] <= 16'sh0000;
                        out_q[g] <= (stop_q[2*g+:2] == STOP_CLR) ? 16'(lo_lim) :
                            (stop_q[2*g+:2] == STOP_MAX) ? 16'(hi_lim) : out_q[g];
                    end else if (st_q[g] == RBL_DONE) begin
                        word_q[g] <= clamped;
                        clamp_q[g] <= clip;
                        if (out_en_q[g]) begin
                            out_q[g] <= clamped;
                        end
                    end
                    if (active && !out_en_q[g]) begin
                        out_q[g] <= (stop_q[2*g+:2] == STOP_CLR) ? 16'(lo_lim) :
                            (stop_q[2*g+:2] == STOP_MAX) ? 16'(hi_lim) : out_q[g];
                    end
                end
            end
            assign scaling_allowed[g] = !active;
        end
    endgenerate

    assign out1_count = out_q[0];
    assign out2_count = out_q[1];
    assign input_word1 = word_q[0];
    assign input_word2 = word_q[1];
    assign conv_done = done_q;

    always_comb begin
        prdata = 32'h0000_0000;
        if (bus_rd) begin
            case (paddr)
                REG_MODE: prdata = {24'h000000, mode_sh_q};
                REG_RATIO1: prdata = {16'h0000, shd_q[0].ratio};
                REG_BIAS1: prdata = {16'h0000, shd_q[0].bias};
                REG_RATIO2: prdata = {16'h0000, shd_q[1].ratio};
                REG_BIAS2: prdata = {16'h0000, shd_q[1].bias};
                REG_CTRL: prdata = {30'h0, out_en_q};
                REG_STOP: prdata = {28'h0, stop_q};
                REG_RESULT1: prdata = {16'h0000, word_q[0]};
                REG_RESULT2: prdata = {16'h0000, word_q[1]};
                REG_STATUS: prdata = {24'h0, hold_all_q, clamp_q, cfg_q[1].mode, cfg_q[0].mode, 1'b0};
                REG_RANGE: prdata = {30'h0, range_q};
                REG_CAL: prdata = {cal_gain_q, cal_ofs_q};
                default: prdata = 32'h0000_0000;
            endcase
        end
    end
endmodule : rbl_loop_conv

// ===== tb/rbl_loop_conv_sva.sv
// Purpose: port-level checks of the two ratio/bias loops
// Assumes: one pclk domain, presetn async active low
// Notes: results land five cycles after the sample edge
`timescale 1ns/100ps
module rbl_loop_conv_sva (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic pslverr, // apb error
    input wire logic [1:0] sample_valid, // sample pulses
    input wire logic [1:0] in_disconnect, // wire break
    input wire logic run_mode, // run mode
    input wire logic adjust_mode, // adjust mode
    input wire logic signed [15:0] out1_count, // output 1
    input wire logic signed [15:0] out2_count, // output 2
    input wire logic signed [15:0] input_word1, // word 1
    input wire logic signed [15:0] input_word2, // word 2
    input wire logic [1:0] scaling_allowed, // scaling permit
    input wire logic [1:0] conv_done // result pulses
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_lat_one: assert property (conv_done[0] |-> $past(sample_valid[0], 5))
        else $error("loop 1 result off time");
    a_lat_two: assert property (conv_done[1] |-> $past(sample_valid[1], 5))
        else $error("loop 2 result off time");
    a_scale_one: assert property (conv_done[0] |-> !scaling_allowed[0])
        else $error("scaling on active loop 1");
    a_scale_two: assert property (conv_done[1] |-> !scaling_allowed[1])
        else $error("scaling on active loop 2");
    a_break_zero: assert property (conv_done[0] && in_disconnect[0]
        && $past(in_disconnect[0], 5) |-> input_word1 == 16'sh0000)
        else $error("broken input result not zero");
    // widest range limit is 8000 plus five percent
    a_clamp_one: assert property (conv_done[0] |-> input_word1 <= 16'sh20D0
        && input_word1 >= -16'sh20D0)
        else $error("loop 1 result unclamped");
    a_clamp_two: assert property (conv_done[1] |-> input_word2 <= 16'sh20D0
        && input_word2 >= -16'sh20D0)
        else $error("loop 2 result unclamped");
    a_adj_freeze: assert property ((run_mode && adjust_mode) [*2] |=>
        $stable(out1_count) && $stable(out2_count) && $stable(input_word1)
        && $stable(input_word2))
        else $error("values moved in adjustment");
    c_done_one: cover property (conv_done[0]);
    c_done_two: cover property (conv_done[1]);
    c_bad_addr: cover property (pslverr);
endmodule : rbl_loop_conv_sva

// ===== tb/rbl_ctrl_model.sv
// Purpose: controller side, hands restart and input samples to the unit
// Assumes: bench raises requests for one cycle
// Notes: counts are inverted between samples so no stale value looks valid
`timescale 1ns/100ps
module rbl_ctrl_model (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic restart_req, // restart wanted
    input wire logic [1:0] sample_req, // samples wanted
    input wire logic signed [15:0] val1, // next input 1
    input wire logic signed [15:0] val2, // next input 2
    output logic unit_restart, // restart pulse
    output logic [1:0] sample_valid, // sample pulses
    output logic signed [15:0] in1_count, // input 1 count
    output logic signed [15:0] in2_count // input 2 count
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_restart <= 1'b0;
            sample_valid <= 2'b00;
            in1_count <= 16'sh0000;
            in2_count <= 16'sh0000;
        end else begin
            unit_restart <= restart_req;
            sample_valid <= sample_req;
            in1_count <= sample_req[0] ? val1 : ~in1_count;
            in2_count <= sample_req[1] ? val2 : ~in2_count;
        end
    end
endmodule : rbl_ctrl_model

// ===== tb/rbl_loop_conv_test.sv
// Purpose: directed run of both loops over apb and the sample path
// Assumes: range code 0 (limits 4200 and -200) unless a scenario sets another
// Notes: ratio 0050 only gives 1400 when read as bcd
`timescale 1ns/100ps
module rbl_loop_conv_test
    import rbl_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rq, unit_restart, er;
    logic run_mode, adjust_mode;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] sreq, sample_valid, in_disconnect, scaling_allowed, conv_done;
    logic signed [15:0] v1, v2, in1_count, in2_count, out1_count, out2_count;
    logic signed [15:0] input_word1, input_word2;
    int mismatches, num_checks;
    rbl_loop_conv rbl_loop_conv_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .unit_restart, .sample_valid, .in1_count,
        .in2_count, .in_disconnect, .run_mode, .adjust_mode, .out1_count, .out2_count,
        .input_word1, .input_word2, .scaling_allowed, .conv_done);
    rbl_ctrl_model rbl_ctrl_model_inst (.pclk, .presetn, .restart_req(rq), .sample_req(sreq),
        .val1(v1), .val2(v2), .unit_restart, .sample_valid, .in1_count, .in2_count);
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 10);
        if (n >= 10) begin
            mismatches++;
            end_of_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic restart();
        @(posedge pclk);
        rq <= 1'b1;
        @(posedge pclk);
        rq <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : restart
    // fixed twelve-cycle window covers the five-cycle result with margin
    task automatic smp(input logic [15:0] a, input logic [15:0] b, input logic [1:0] m);
        logic [1:0] seen;
        seen = 2'b00;
        @(posedge pclk);
        sreq <= 2'b11;
        v1 <= a;
        v2 <= b;
        @(posedge pclk);
        sreq <= 2'b00;
        for (int i = 0; i < 12; i++) begin
            @(posedge pclk);
            #1;
            seen = seen | conv_done;
        end
        if ((seen & m) !== m) begin
            mismatches++;
            end_of_test();
        end
    endtask : smp
    task automatic outs(input logic [31:0] w1, o1, w2, o2);
        chk("word1", input_word1, w1);
        chk("out1", out1_count, o1);
        chk("word2", input_word2, w2);
        chk("out2", out2_count, o2);
    endtask : outs
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, rq, adjust_mode} = 6'h00;
        run_mode = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        {sreq, in_disconnect, v1, v2} = 36'h0;
        mismatches = 0;
        num_checks = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, REG_MODE, 32'h0);
        chk("mode_reset", rd, 32'h0);
        apb(1'b0, 8'h30, 32'h0);
        chk("bad_err", {31'h0, er}, 32'h1);
        chk("bad_data", rd, 32'h0);
        // offset and gain always go in together, as one word
        apb(1'b1, REG_CAL, 32'h0FA0_0000);
        apb(1'b0, REG_CAL, 32'h0);
        chk("cal_pair", rd, 32'h0FA0_0000);
        apb(1'b1, REG_MODE, 32'h9);
        apb(1'b1, REG_RATIO1, 32'h50);
        apb(1'b1, REG_BIAS1, 32'h190);
        apb(1'b1, REG_RATIO2, 32'h1000);
        apb(1'b1, REG_BIAS2, 32'hC8);
        apb(1'b1, REG_CTRL, 32'h3);
        apb(1'b0, REG_MODE, 32'h0);
        chk("mode_shadow", rd, 32'h9);
        smp(16'h07D0, 16'h012C, 2'b00);
        chk("raw_word1", input_word1, 32'h7D0);
        restart();
        smp(16'h07D0, 16'h012C, 2'b11);
        outs(32'h578, 32'h578, 32'h4B0, 32'h4B0);
        chk("scal_on", scaling_allowed, 32'h0);
        apb(1'b0, REG_RESULT2, 32'h0);
        chk("result2", rd, 32'h4B0);
        apb(1'b1, REG_RATIO1, 32'h100);
        smp(16'h07D0, 16'h012C, 2'b11);
        chk("old_ratio", input_word1, 32'h578);
        restart();
        smp(16'h1F40, 16'h03E8, 2'b11);
        outs(32'h1068, 32'h1068, 32'hFFFFFF38, 32'hFFFFFF38);
        @(posedge pclk);
        in_disconnect <= 2'b01;
        smp(16'h1F40, 16'h03E8, 2'b10);
        chk("break_word", input_word1, 32'h0);
        chk("break_out", out1_count, 32'hFFFFFF38);
        @(posedge pclk);
        in_disconnect <= 2'b00;
        apb(1'b1, REG_CTRL, 32'h2);
        // code 1 after code 0 must keep -200, which tells hold from high limit
        for (int c = 0; c < 3; c++) begin
            apb(1'b1, REG_STOP, 32'(c));
            smp(16'h07D0, 16'h012C, 2'b10);
            chk("stop_out", out1_count, (c == 2) ? 32'h1068 : 32'hFFFFFF38);
        end
        // bipolar 4000 then unipolar 8000 counts; output 1 stays at stop code 2
        apb(1'b1, REG_RANGE, 32'h1);
        smp(16'h1F40, 16'h03E8, 2'b11);
        outs(32'h834, 32'h834, 32'hFFFFF7CC, 32'hFFFFF7CC);
        apb(1'b1, REG_RANGE, 32'h2);
        smp(16'h1F40, 16'h03E8, 2'b11);
        outs(32'h20D0, 32'h20D0, 32'hFFFFFE70, 32'hFFFFFE70);
        apb(1'b1, REG_RANGE, 32'h0);
        apb(1'b1, REG_MODE, 32'hF3);
        restart();
        smp(16'h07D0, 16'h012C, 2'b00);
        chk("off_word1", input_word1, 32'h7D0);
        chk("off_word2", input_word2, 32'h12C);
        chk("off_scal", scaling_allowed, 32'h3);
        @(posedge pclk);
        adjust_mode <= 1'b1;
        smp(16'h0064, 16'h0064, 2'b00);
        chk("frozen", input_word1, 32'h7D0);
        // frozen flag, loop 2 clamp flag left from the 8000 run, both modes 11/00
        apb(1'b0, REG_STATUS, 32'h0);
        chk("status_frz", rd, 32'hC6);
        // program mode first: adjustment then leaves the loops running
        @(posedge pclk);
        run_mode <= 1'b0;
        smp(16'h0064, 16'h0064, 2'b00);
        chk("prog_adj", input_word1, 32'h64);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, REG_MODE, 32'h0);
        chk("mode_rst2", rd, 32'h0);
        outs(32'h0, 32'h0, 32'h0, 32'h0);
        end_of_test();
    end
endmodule : rbl_loop_conv_test
bind rbl_loop_conv rbl_loop_conv_sva rbl_loop_conv_sva_inst (.pclk, .presetn, .pslverr,
    .sample_valid, .in_disconnect, .run_mode, .adjust_mode, .out1_count, .out2_count,
    .input_word1, .input_word2, .scaling_allowed, .conv_done);
